// *** shared/asfr_pkg.sv ***
// Purpose: Constants and types for the sample buffer readout block
// Assumes: 8-bit register space reached over a two-wire serial link
// Notes:   Bit positions and reset values are named here only
package asfr_pkg;
   // ==========================================================
   // Register addresses
   localparam logic [7:0] ADR_LIVE_XH   = 8'h01;
   localparam logic [7:0] ADR_LIVE_YH   = 8'h02;
   localparam logic [7:0] ADR_LIVE_ZH   = 8'h03;
   localparam logic [7:0] ADR_LIVE_XL   = 8'h05;
   localparam logic [7:0] ADR_LIVE_XHW  = 8'h06;
   localparam logic [7:0] ADR_LIVE_YL   = 8'h07;
   localparam logic [7:0] ADR_LIVE_YHW  = 8'h08;
   localparam logic [7:0] ADR_LIVE_ZL   = 8'h09;
   localparam logic [7:0] ADR_LIVE_ZHW  = 8'h0A;
   localparam logic [7:0] ADR_STATUS    = 8'h10;
   localparam logic [7:0] ADR_NARROW    = 8'h11;
   localparam logic [7:0] ADR_WIDE      = 8'h12;
   localparam logic [7:0] ADR_SETUP     = 8'h13;
   localparam logic [7:0] ADR_SYSSTATE  = 8'h14;
   localparam logic [7:0] ADR_INTORIG   = 8'h15;
   localparam logic [7:0] ADR_DATACFG   = 8'h16;
   localparam logic [7:0] ADR_CUTOFF    = 8'h17;
   // ==========================================================
   // Fields and reset values
   localparam int         CFG_FDE_BIT   = 7;
   localparam int         INT_BUF_BIT   = 6;
   localparam int         SYS_GERR_BIT  = 7;
   localparam int         SYS_PERR_BIT  = 6;
   localparam logic [7:0] REG_RST       = 8'h00;
   localparam logic [1:0] MODE_OFF      = 2'h0;
   localparam logic [1:0] MODE_CIRC     = 2'h1;
   localparam logic [1:0] MODE_FILL     = 2'h2;
   // ==========================================================
   // Buffer geometry
   localparam int         DEPTH         = 32;
   localparam logic [5:0] CNT_FULL      = 6'h20;
   localparam logic [5:0] CNT_ZERO      = 6'h00;
   localparam logic [2:0] LAST_NARROW   = 3'h2;
   localparam logic [2:0] LAST_WIDE     = 3'h5;
   localparam logic [3:0] BITS_BYTE     = 4'h8;
   localparam logic [3:0] BIT_LAST      = 4'h7;
   // ==========================================================
   // Types
   typedef struct packed {
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] z;
   } asfr_sample_s;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_ADDR  = 6'b000010,
      ST_ACK   = 6'b000100,
      ST_RX    = 6'b001000,
      ST_TX    = 6'b010000,
      ST_TXACK = 6'b100000
   } asfr_state_e;
endpackage

// *** logic/asfr_readout.sv ***
// Purpose: Sample buffer with serial-link register readout
// Assumes: sampleClk domain delivers converted samples; link via pins
// Notes:   Link pins oversampled on clk; samples cross by toggle
// Behaviour
// - Six-bit stored-sample count; zero means empty.
// - Holds up to 32 samples; watermark setting drives watermark flag.
// - Reads at 0x01 give oldest sample, X, Y, Z upper bytes.
// - Reading past the stored samples returns 0x00.
// - Reads at 0x05 give oldest sample, six bytes low/high per axis.
// - With buffer output on, other output data addresses read zero.
// - During a buffer read, no new samples stored until STOP or START.
// - Reading the last buffer byte of a sample consumes it, count drops by one.
// - Count above watermark does not stop sample acceptance.
// - Samples enter at wake rate, or sleep rate when auto-sleeping.
// - Two-bit mode field selects three states, one disabled.
// - Gate error sets if not emptied before next sample; empty clears.
// - Read-only system state shows mode, parity and gate errors.
// - Source flags set on rising condition, cleared by status read.
// - Config bit 7 enables buffer output; clear shows live samples.
// - Watermark and overflow flags stay while their condition holds.
// - Status read clears buffer interrupt flag; level flags remain.
`timescale 1ns/1ps
module asfr_readout
   import asfr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
)(
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic         sampleClk,
   input  wire logic         sampleValid,
   input  wire asfr_sample_s sampleIn,
   input  wire logic [2:0]   wakeRate,
   input  wire logic [2:0]   sleepRate,
   input  wire logic         autoSleep,
   input  wire logic         gateEn,
   input  wire logic         parityErr,
   input  wire logic [1:0]   opMode,
   input  wire logic         sclIn,
   input  wire logic         sdaIn,
   output logic              sdaOut,
   output logic              sdaOe
);
   // ==========================================================
   // Sample domain capture
   asfr_sample_s smpHold_r;
   logic         smpTgl_r;

   always_ff @(posedge sampleClk or posedge reset) begin
      if (reset) begin
         smpHold_r <= '0;
         smpTgl_r  <= 1'b0;
      end else if (sampleValid) begin
         smpHold_r <= sampleIn;
         smpTgl_r  <= ~smpTgl_r;
      end
   end

   // ==========================================================
   // Crossings and pin synchronisers
   logic [2:0] tglSy_r;
   logic [2:0] sclSy_r;
   logic [2:0] sdaSy_r;
   logic       tglSeen_r;
   logic       sclS_r;
   logic       sdaS_r;
   logic       sclP_r;
   logic       sdaP_r;
   logic       smpEvt;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tglSy_r <= '0;
         sclSy_r <= 3'h7;
         sdaSy_r <= 3'h7;
      end else begin
         tglSy_r <= {tglSy_r[1:0], smpTgl_r};
         sclSy_r <= {sclSy_r[1:0], sclIn};
         sdaSy_r <= {sdaSy_r[1:0], sdaIn};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tglSeen_r <= 1'b0;
         sclS_r    <= 1'b1;
         sdaS_r    <= 1'b1;
         sclP_r    <= 1'b1;
         sdaP_r    <= 1'b1;
      end else begin
         if (tglSy_r[1] == tglSy_r[2])
            tglSeen_r <= tglSy_r[2];
         if (sclSy_r[1] == sclSy_r[2])
            sclS_r <= sclSy_r[2];
         if (sdaSy_r[1] == sdaSy_r[2])
            sdaS_r <= sdaSy_r[2];
         sclP_r <= sclS_r;
         sdaP_r <= sdaS_r;
      end
   end

   assign smpEvt = (tglSy_r[1] == tglSy_r[2]) &&
                   (tglSy_r[2] != tglSeen_r);

   // ==========================================================
   // Link conditions
   logic sclRise;
   logic sclFall;
   logic busStart;
   logic busStop;

   assign sclRise  = sclS_r & ~sclP_r;
   assign sclFall  = ~sclS_r & sclP_r;
   assign busStart = sclS_r & sclP_r & sdaP_r & ~sdaS_r;
   assign busStop  = sclS_r & sclP_r & ~sdaP_r & sdaS_r;

   // ==========================================================
   // Registers and buffer state
   asfr_sample_s mem_r [DEPTH];
   asfr_sample_s live_r;
   logic [7:0]   setup_r;
   logic [7:0]   dataCfg_r;
   logic [7:0]   cutoff_r;
   logic [5:0]   cnt_r;
   logic [4:0]   head_r;
   logic [4:0]   tail_r;
   logic [2:0]   byteIdx_r;
   logic [6:0]   decim_r;
   logic         ovf_r;
   logic         gateErr_r;
   logic         intBuf_r;
   logic         evtLvl_r;
   logic         readHold_r;
   logic [1:0]   mode;
   logic         fde;
   logic         full;
   logic         accept;
   logic         push;
   logic         pop;
   logic         wmHit;
   logic         evtLvl;

   function automatic logic isBuf(input logic [7:0] a, input logic f);
      isBuf = (a == ADR_NARROW) || (a == ADR_WIDE) ||
              (f && (a == ADR_LIVE_XH || a == ADR_LIVE_XL));
   endfunction

   function automatic logic isWide(input logic [7:0] a);
      isWide = (a == ADR_WIDE) || (a == ADR_LIVE_XL);
   endfunction

   function automatic logic [7:0] axByte(input logic [11:0] v,
                                         input logic        hi);
      axByte = hi ? v[11:4] : {v[3:0], 4'h0};
   endfunction

   assign mode  = setup_r[7:6];
   assign fde   = dataCfg_r[CFG_FDE_BIT];
   assign full  = (cnt_r == CNT_FULL);
   assign wmHit = (cnt_r > setup_r[5:0]);
   assign evtLvl = ovf_r | wmHit;

   assign accept = smpEvt && (decim_r == 7'h00);

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         decim_r <= 7'h00;
      else if (smpEvt)
         decim_r <= (decim_r + 7'h01) &
                    7'((8'h01 << (autoSleep ? sleepRate : wakeRate))
                       - 8'h01);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         live_r <= '0;
      else if (accept)
         live_r <= smpHold_r;
   end

   // ==========================================================
   // Link engine
   asfr_state_e st_r;
   logic [3:0]  bitCnt_r;
   logic [7:0]  shift_r;
   logic [7:0]  txShift_r;
   logic [7:0]  ptr_r;
   logic        isRead_r;
   logic        gotPtr_r;
   logic        more_r;
   logic        loadEvt;
   logic        wrEvt;
   logic [7:0]  ldPtr;
   logic [7:0]  rdData;
   logic        ldBuf;
   asfr_sample_s hd;

   assign loadEvt = sclFall && ((st_r == ST_ACK && isRead_r) ||
                    (st_r == ST_TXACK && more_r));
   assign wrEvt   = sclFall && st_r == ST_RX && bitCnt_r == BITS_BYTE &&
                    gotPtr_r;
   assign ldPtr   = (st_r == ST_ACK || isBuf(ptr_r, fde)) ?
                    ptr_r : ptr_r + 8'h01;
   assign ldBuf   = isBuf(ldPtr, fde);
   assign hd      = mem_r[head_r];

   // Read multiplexer
   always_comb begin
      rdData = REG_RST;
      if (ldBuf) begin
         if (cnt_r != CNT_ZERO) begin
            unique case (isWide(ldPtr) ? byteIdx_r : byteIdx_r << 1)
               3'h0: rdData = axByte(hd.x, !isWide(ldPtr));
               3'h1: rdData = axByte(hd.x, 1'b1);
               3'h2: rdData = axByte(hd.y, !isWide(ldPtr));
               3'h3: rdData = axByte(hd.y, 1'b1);
               3'h4: rdData = axByte(hd.z, !isWide(ldPtr));
               3'h5: rdData = axByte(hd.z, 1'b1);
               default: rdData = REG_RST;
            endcase
         end
      end else if (fde && ldPtr > ADR_LIVE_XH &&
                   ldPtr <= ADR_LIVE_ZHW) begin
         rdData = REG_RST;
      end else begin
         unique case (ldPtr)
            ADR_LIVE_XH, ADR_LIVE_XHW: rdData = axByte(live_r.x, 1'b1);
            ADR_LIVE_YH, ADR_LIVE_YHW: rdData = axByte(live_r.y, 1'b1);
            ADR_LIVE_ZH, ADR_LIVE_ZHW: rdData = axByte(live_r.z, 1'b1);
            ADR_LIVE_XL:  rdData = axByte(live_r.x, 1'b0);
            ADR_LIVE_YL:  rdData = axByte(live_r.y, 1'b0);
            ADR_LIVE_ZL:  rdData = axByte(live_r.z, 1'b0);
            ADR_STATUS:   rdData = {ovf_r, wmHit, cnt_r};
            ADR_SETUP:    rdData = setup_r;
            ADR_SYSSTATE: rdData = {gateErr_r, parityErr, 4'h0, opMode};
            ADR_INTORIG:  rdData = 8'(intBuf_r) << INT_BUF_BIT;
            ADR_DATACFG:  rdData = dataCfg_r;
            ADR_CUTOFF:   rdData = cutoff_r;
            default:      rdData = REG_RST;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r      <= ST_IDLE;
         bitCnt_r  <= 4'h0;
         shift_r   <= 8'h00;
         txShift_r <= 8'h00;
         ptr_r     <= 8'h00;
         isRead_r  <= 1'b0;
         gotPtr_r  <= 1'b0;
         more_r    <= 1'b0;
         sdaOe     <= 1'b0;
      end else if (busStart) begin
         st_r     <= ST_ADDR;
         bitCnt_r <= 4'h0;
         gotPtr_r <= 1'b0;
         sdaOe    <= 1'b0;
      end else if (busStop) begin
         st_r  <= ST_IDLE;
         sdaOe <= 1'b0;
      end else begin
         if (sclRise && (st_r == ST_ADDR || st_r == ST_RX)) begin
            shift_r  <= {shift_r[6:0], sdaS_r};
            bitCnt_r <= bitCnt_r + 4'h1;
         end
         if (sclRise && st_r == ST_TXACK)
            more_r <= ~sdaS_r;
         if (loadEvt) begin
            ptr_r     <= ldPtr;
            txShift_r <= rdData;
            sdaOe     <= ~rdData[7];
            bitCnt_r  <= 4'h0;
            st_r      <= ST_TX;
         end else if (sclFall) begin
            unique case (st_r)
               ST_ADDR: if (bitCnt_r == BITS_BYTE) begin
                  if (shift_r[7:1] == DEV_ADDR) begin
                     isRead_r <= shift_r[0];
                     sdaOe    <= 1'b1;
                     st_r     <= ST_ACK;
                  end else
                     st_r <= ST_IDLE;
               end
               ST_RX: if (bitCnt_r == BITS_BYTE) begin
                  if (!gotPtr_r)
                     ptr_r <= shift_r;
                  else
                     ptr_r <= ptr_r + 8'h01;
                  gotPtr_r <= 1'b1;
                  sdaOe    <= 1'b1;
                  st_r     <= ST_ACK;
               end
               ST_ACK: begin
                  sdaOe    <= 1'b0;
                  bitCnt_r <= 4'h0;
                  st_r     <= ST_RX;
               end
               ST_TX: if (bitCnt_r == BIT_LAST) begin
                  sdaOe <= 1'b0;
                  st_r  <= ST_TXACK;
               end else begin
                  txShift_r <= {txShift_r[6:0], 1'b0};
                  sdaOe     <= ~txShift_r[6];
                  bitCnt_r  <= bitCnt_r + 4'h1;
               end
               ST_TXACK: st_r <= ST_IDLE;
               default:  st_r <= ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         sdaOut <= 1'b0;
      else
         sdaOut <= 1'b0;
   end

   // ==========================================================
   // Register writes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         setup_r   <= REG_RST;
         dataCfg_r <= REG_RST;
         cutoff_r  <= REG_RST;
      end else if (wrEvt) begin
         unique case (ptr_r)
            ADR_SETUP:   setup_r   <= shift_r;
            ADR_DATACFG: dataCfg_r <= shift_r;
            ADR_CUTOFF:  cutoff_r  <= shift_r;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Buffer control
   // Hold off storing during buffer read
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         readHold_r <= 1'b0;
      else if (busStart || busStop)
         readHold_r <= 1'b0;
      else if (loadEvt && ldBuf)
         readHold_r <= 1'b1;
   end

   assign push = accept && !readHold_r &&
                 (mode == MODE_CIRC || (mode == MODE_FILL && !full));
   // Consume sample when its last byte is loaded for sending
   assign pop  = loadEvt && ldBuf && cnt_r != CNT_ZERO &&
                 byteIdx_r == (isWide(ldPtr) ? LAST_WIDE : LAST_NARROW);

   always_ff @(posedge clk) begin
      if (push)
         mem_r[tail_r] <= smpHold_r;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r     <= CNT_ZERO;
         head_r    <= 5'h00;
         tail_r    <= 5'h00;
         byteIdx_r <= 3'h0;
      end else if (mode != MODE_CIRC && mode != MODE_FILL) begin
         cnt_r     <= CNT_ZERO;
         head_r    <= 5'h00;
         tail_r    <= 5'h00;
         byteIdx_r <= 3'h0;
      end else begin
         if (loadEvt && ldBuf && cnt_r != CNT_ZERO)
            byteIdx_r <= pop ? 3'h0 : byteIdx_r + 3'h1;
         if (push)
            tail_r <= tail_r + 5'h01;
         if (pop || (push && full))
            head_r <= head_r + 5'h01;
         if (push && !pop && !full)
            cnt_r <= cnt_r + 6'h01;
         else if (pop && !push)
            cnt_r <= cnt_r - 6'h01;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         ovf_r <= 1'b0;
      else if (mode != MODE_CIRC && mode != MODE_FILL)
         ovf_r <= 1'b0;
      else if (accept && full)
         ovf_r <= 1'b1;
      else if (pop)
         ovf_r <= 1'b0;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         gateErr_r <= 1'b0;
      else if (gateEn && accept && cnt_r != CNT_ZERO)
         gateErr_r <= 1'b1;
      else if (cnt_r == CNT_ZERO)
         gateErr_r <= 1'b0;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         evtLvl_r <= 1'b0;
         intBuf_r <= 1'b0;
      end else begin
         evtLvl_r <= evtLvl;
         if (evtLvl && !evtLvl_r)
            intBuf_r <= 1'b1;
         else if (loadEvt && ldPtr == ADR_STATUS)
            intBuf_r <= 1'b0;
      end
   end

   // ==========================================================
   // Assertions
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   AST_COUNT_MAX: assert property (cnt_r <= CNT_FULL)
      else $error("count above depth");
   AST_EMPTY_ZERO: assert property (
      loadEvt && ldBuf && cnt_r == CNT_ZERO |=> txShift_r == 8'h00)
      else $error("empty buffer read not zero");
   AST_OTHER_ZERO: assert property (
      loadEvt && fde && ldPtr == ADR_LIVE_YH |=> txShift_r == 8'h00)
      else $error("other data address not zero");
   AST_HOLD: assert property (
      readHold_r && !busStart && !busStop |=> cnt_r <= $past(cnt_r))
      else $error("sample stored during buffer read");
   AST_POP: assert property (
      pop && !push |=> cnt_r == $past(cnt_r) - 6'h01)
      else $error("pop did not reduce count");
   AST_GERR: assert property (
      gateErr_r && cnt_r != CNT_ZERO |=> gateErr_r)
      else $error("gate error dropped early");
   AST_EDGE: assert property (
      $rose(evtLvl) |=> intBuf_r)
      else $error("source flag not set on rise");
   AST_STAT_CLR: assert property (
      loadEvt && ldPtr == ADR_STATUS && !(evtLvl && !evtLvl_r)
      |=> !intBuf_r)
      else $error("status read did not clear flag");
   AST_DISABLE: assert property (
      mode == MODE_OFF |=> cnt_r == CNT_ZERO && !ovf_r)
      else $error("disabled mode not flushed");

   COV_FULL: cover property (push ##1 full);
   COV_DRAIN: cover property (pop ##1 cnt_r == CNT_ZERO);
   COV_OVF: cover property ($rose(ovf_r));
endmodule

// *** tb/asfr_host.sv ***
// Purpose: Serial-link host model for register access
// Assumes: SDA is resolved in the bench with a pull-up
// Notes:   SCL low 250 ns, high 200 ns; data moves 2 clk after fall
`timescale 1ns/1ps
module asfr_host #(
   parameter logic [6:0] ADDR = 7'h2A
)(
   input  wire logic clk,
   input  wire logic sdaLine,
   output logic      sclPin,
   output logic      sdaPull
);
   int nakCnt = 0;
   initial begin
      sclPin = 1'h1;
      sdaPull = 1'h0;
   end
   // ==========================================================
   // Bit level
   task automatic hb();
      repeat (8) @(negedge clk);
   endtask
   task automatic bitx(input logic b, output logic r);
      sdaPull = ~b;
      hb();
      sclPin = 1'h1;
      hb();
      r = sdaLine;
      sclPin = 1'h0;
      repeat (2) @(negedge clk);
   endtask
   task automatic start();
      sdaPull = 1'h0;
      hb();
      sclPin = 1'h1;
      hb();
      sdaPull = 1'h1;
      hb();
      sclPin = 1'h0;
      repeat (2) @(negedge clk);
   endtask
   task automatic stop();
      sdaPull = 1'h1;
      hb();
      sclPin = 1'h1;
      hb();
      sdaPull = 1'h0;
      hb();
   endtask
   // ==========================================================
   // Byte level
   task automatic xfer(input logic [7:0] d, input logic rd, last,
                       output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
      bitx(rd ? last : 1'h1, a);
      if (!rd && a) nakCnt++;
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
      logic [7:0] r;
      start();
      xfer({ADDR, 1'h0}, 1'h0, 1'h0, r);
      xfer(ptr, 1'h0, 1'h0, r);
      xfer(val, 1'h0, 1'h0, r);
      stop();
   endtask
   task automatic rd(input logic [7:0] ptr, input int n,
                     output logic [7:0] q[$]);
      logic [7:0] r;
      q = {};
      start();
      xfer({ADDR, 1'h0}, 1'h0, 1'h0, r);
      xfer(ptr, 1'h0, 1'h0, r);
      start();
      xfer({ADDR, 1'h1}, 1'h0, 1'h0, r);
      for (int i = 0; i < n; i++) begin
         xfer(8'hFF, 1'h1, i == n - 1, r);
         q.push_back(r);
      end
      stop();
   endtask
endmodule

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the sample buffer readout
// Assumes: Host model on the link, samples on a 160 ns clock
// Notes:   Model queue tracks stored samples and flags
`timescale 1ns/1ps
module tb;
   import asfr_pkg::*;
   localparam logic [6:0] DA = 7'h2A;
   logic         clk, reset, sampleClk, sampleValid;
   logic         autoSleep, gateEn, parityErr, mOvf;
   logic         sclPin, sdaPull, sdaOut, sdaOe, sdaLine;
   logic [2:0]   wakeRate, sleepRate;
   logic [1:0]   opMode, mMode;
   logic [5:0]   mWm;
   logic [7:0]   q[$];
   logic [31:0]  seed = 32'h864D7F17;
   asfr_sample_s sampleIn, lastS;
   asfr_sample_s mq[$];
   int           failures = 0;
   int           checks = 0;
   assign sdaLine = ~(sdaOe | sdaPull);
   asfr_readout #(.DEV_ADDR(DA)) dut_u (.clk(clk), .reset(reset),
      .sampleClk(sampleClk), .sampleValid(sampleValid),
      .sampleIn(sampleIn), .wakeRate(wakeRate), .sleepRate(sleepRate),
      .autoSleep(autoSleep), .gateEn(gateEn), .parityErr(parityErr),
      .opMode(opMode), .sclIn(sclPin), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe));
   asfr_host #(.ADDR(DA)) host_u (.clk(clk), .sdaLine(sdaLine),
      .sclPin(sclPin), .sdaPull(sdaPull));
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      sampleClk = 1'h0;
      #7;
      forever #80 sampleClk = ~sampleClk;
   end
   // ==========================================================
   // Model and helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] stat();
      return {mOvf, mq.size() > mWm, 6'(mq.size())};
   endfunction
   function automatic logic [7:0] bsel(asfr_sample_s s, int per, int k);
      logic [11:0] a;
      a = (per == 3) ? (k == 0 ? s.x : k == 1 ? s.y : s.z)
                     : (k < 2 ? s.x : k < 4 ? s.y : s.z);
      if (per == 3 || k[0]) return a[11:4];
      return {a[3:0], 4'h0};
   endfunction
   task automatic chk(input logic [7:0] e, input logic [7:0] got);
      checks++;
      if (got !== e) begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, got);
      end
   endtask
   task automatic rdReg(input logic [7:0] ptr, input logic [7:0] e);
      host_u.rd(ptr, 1, q);
      chk(e, q[0]);
   endtask
   task automatic rdBuf(input logic [7:0] ptr, input int n);
      int per;
      per = (ptr == ADR_LIVE_XH || ptr == ADR_NARROW) ? 3 : 6;
      host_u.rd(ptr, n, q);
      for (int i = 0; i < n; i++) begin
         chk(mq.size() > 0 ? bsel(mq[0], per, i % per) : 8'h00, q[i]);
         if (i % per == per - 1 && mq.size() > 0) begin
            void'(mq.pop_front());
            mOvf = 1'h0;
         end
      end
   endtask
   task automatic push(input logic keep);
      asfr_sample_s s;
      s = 36'({xs(), xs()});
      @(negedge sampleClk);
      sampleValid = 1'h1;
      sampleIn = s;
      @(negedge sampleClk);
      sampleValid = 1'h0;
      repeat (4) @(negedge sampleClk);
      if (keep && (mMode == MODE_CIRC || mMode == MODE_FILL)) begin
         lastS = s;
         if (mq.size() == DEPTH) begin
            mOvf = 1'h1;
            if (mMode == MODE_CIRC) void'(mq.pop_front());
         end
         if (mq.size() < DEPTH) mq.push_back(s);
      end
   endtask
   task automatic setMode(input logic [1:0] m, input logic [5:0] wm);
      host_u.wr(ADR_SETUP, {MODE_OFF, wm});
      host_u.wr(ADR_SETUP, {m, wm});
      mq = {};
      {mMode, mWm, mOvf} = {m, wm, 1'h0};
   endtask
   task automatic end_of_test();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk);
      failures++;
      end_of_test();
   end
   // ==========================================================
   // Scenarios
   initial begin
      {sampleValid, sampleIn, lastS} = '0;
      reset = 1'h1;
      {wakeRate, sleepRate, autoSleep, gateEn} = 8'h04;
      parityErr = 1'h1;
      opMode = 2'(xs());
      {mMode, mWm, mOvf} = 9'h000;
      repeat (6) @(negedge clk);
      reset = 1'h0;
      repeat (6) @(negedge clk);
      rdReg(ADR_STATUS, 8'h00);
      rdReg(ADR_SYSSTATE, {2'h1, 4'h0, opMode});
      $display("done: reset");
      setMode(MODE_CIRC, 6'h03);
      host_u.wr(ADR_DATACFG, 8'h80);
      rdReg(ADR_DATACFG, 8'h80);
      rdReg(ADR_SETUP, {MODE_CIRC, 6'h03});
      repeat (5) push(1'h1);
      rdReg(ADR_INTORIG, 8'h40);
      rdReg(ADR_STATUS, stat());
      rdReg(ADR_INTORIG, 8'h00);
      $display("done: watermark");
      rdReg(ADR_LIVE_YH, 8'h00);
      rdReg(ADR_LIVE_ZHW, 8'h00);
      host_u.wr(ADR_DATACFG, 8'h00);
      rdReg(ADR_LIVE_XH, lastS.x[11:4]);
      host_u.wr(ADR_DATACFG, 8'h80);
      rdBuf(ADR_LIVE_XH, 6);
      rdReg(ADR_STATUS, stat());
      rdBuf(ADR_LIVE_XL, 20);
      $display("done: readout");
      for (int k = 1; k < 3; k++) begin
         setMode(2'(k), 6'h1F);
         rdReg(ADR_STATUS, 8'h00);
         repeat (33) push(1'h1);
         rdReg(ADR_STATUS, stat());
         rdBuf(k == 1 ? ADR_LIVE_XH : ADR_NARROW, 3);
         rdReg(ADR_STATUS, stat());
      end
      $display("done: overflow");
      setMode(MODE_CIRC, 6'h1F);
      push(1'h1);
      fork
         rdBuf(ADR_LIVE_XH, 3);
         begin
            repeat (720) @(negedge clk);
            push(1'h0);
         end
      join
      rdReg(ADR_STATUS, stat());
      $display("done: read hold");
      gateEn = 1'h1;
      repeat (2) push(1'h1);
      rdReg(ADR_SYSSTATE, {2'h3, 4'h0, opMode});
      rdBuf(ADR_WIDE, 12);
      parityErr = 1'h0;
      rdReg(ADR_SYSSTATE, {2'h0, 4'h0, opMode});
      gateEn = 1'h0;
      $display("done: gate error");
      setMode(MODE_CIRC, 6'h3F);
      autoSleep = 1'h1;
      repeat (4) push(1'h0);
      rdReg(ADR_STATUS, 8'h02);
      autoSleep = 1'h0;
      repeat (2) push(1'h0);
      rdReg(ADR_STATUS, 8'h04);
      setMode(2'h3, 6'h00);
      push(1'h1);
      rdReg(ADR_STATUS, 8'h00);
      chk(8'h00, 8'(host_u.nakCnt));
      chk(8'h00, {7'h00, sdaOut});
      $display("done: rates and modes");
      end_of_test();
   end
endmodule
